// file: logic/rbx_exec_core.sv
/*
 * rbx_exec_core: executes conditional and unconditional relative branches and
 * the file bit set instruction over a four-phase instruction cycle, with
 * program counter, flags, bank select and a flip-flop data memory reached over
 * a classic Wishbone slave.
 * assumes: one clock, synchronous active-high reset, a classic single-cycle
 * Wishbone master; flags are produced elsewhere and loaded by software.
 */
// Local design decisions: the address map and the Wishbone slave port.
// Contract
// - 1110 0011 branches when carry clear
// - 1110 0111 branches when negative clear
// - 1110 0101 branches when overflow clear
// - 1110 0001 branches when zero clear
// - conditional offset is signed eight bits
// - target is incremented counter plus twice offset
// - one cycle untaken, two taken, nop second
// - 1101 0 branches always, two cycles
// - jump offset signed eleven bits, doubled
// - 1000 sets chosen file bit, read-modify-write
// - access bit picks access bank or bank register
// - extended set indexes low access addresses
`timescale 1ns/1ps

module rbx_exec_core
    import rbx_pkg::*;
#(
    parameter int DATA_AW = DATA_AW_DFLT
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [PC_W-1:0] pc_o,
    output logic busy_o
);

    localparam int DEPTH = 1 << DATA_AW;

    logic [1:0] phase;
    logic cycle_end;
    rbx_state_t state_r;
    logic pending_r;
    logic [INSTR_W-1:0] instr_r;
    logic [PC_W-1:0] pc_r;
    logic [7:0] flags_r;
    logic [3:0] bank_r;
    logic [FADDR_W-1:0] ibase_r;
    logic ext_en_r;
    logic [DATA_AW-1:0] daddr_r;
    logic [7:0] mem_r [DEPTH];

    rbx_kind_t dec_kind;
    logic dec_taken;
    logic [PC_W-1:0] dec_off2;
    logic [FADDR_W-1:0] dec_faddr;
    logic [2:0] dec_bit;

    rbx_kind_t kind_r;
    logic taken_r;
    logic [PC_W-1:0] off2_r;
    logic [FADDR_W-1:0] faddr_r;
    logic [2:0] bit_r;
    logic [7:0] rd_r;
    logic [7:0] wr_r;
    logic last_taken_r;
    logic unsup_r;
    logic refused_r;
    logic ack_r;
    logic [31:0] dat_r;

    logic req;
    logic wr_go;
    logic idle;
    logic reg_busy;
    logic refuse_ev;
    logic [31:0] wmask;
    logic [31:0] rd_mux;

    rbx_qphase u_qphase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .phase_o(phase),
        .cycle_end_o(cycle_end)
    );

    rbx_decode u_decode (
        .instr_i(instr_r),
        .flags_i(flags_r),
        .bank_i(bank_r),
        .ext_en_i(ext_en_r),
        .ibase_i(ibase_r),
        .kind_o(dec_kind),
        .taken_o(dec_taken),
        .offset2_o(dec_off2),
        .faddr_o(dec_faddr),
        .bit_o(dec_bit)
    );

    // bus request decode; a write lands on the edge where ack is seen high
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_go = req & wb_we_i & ack_r;
    assign idle = (state_r == SM_IDLE);
    // state that the executing instruction owns cannot be rewritten mid-flight
    assign reg_busy = ~idle | pending_r;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    always_comb
    begin
        refuse_ev = 1'b0;
        if (wr_go && reg_busy)
        begin
            case (wb_adr_i)
                OFF_INSTR, OFF_PC, OFF_FLAGS, OFF_BANK, OFF_IBASE, OFF_CTRL, OFF_DDATA:
                begin
                    refuse_ev = 1'b1;
                end
                default:
                begin
                    refuse_ev = 1'b0;
                end
            endcase
        end
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            OFF_CTRL: rd_mux = {31'h0, ext_en_r};
            OFF_FLAGS: rd_mux = {24'h0, flags_r};
            OFF_PC: rd_mux = {{(32-PC_W){1'b0}}, pc_r};
            OFF_BANK: rd_mux = {28'h0, bank_r};
            OFF_IBASE: rd_mux = {{(32-FADDR_W){1'b0}}, ibase_r};
            OFF_INSTR: rd_mux = {{(32-INSTR_W){1'b0}}, instr_r};
            OFF_STATE: rd_mux = {28'h0, refused_r, unsup_r, last_taken_r, reg_busy};
            OFF_DADDR: rd_mux = {{(32-DATA_AW){1'b0}}, daddr_r};
            OFF_DDATA: rd_mux = {24'h0, mem_r[daddr_r]};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // classic slave: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= req & ~ack_r;
            if (req & ~ack_r)
            begin
                dat_r <= rd_mux;
            end
        end
    end

    // software-owned configuration
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_en_r <= 1'b0;
            bank_r <= BANK_RST;
            ibase_r <= IBASE_RST;
            daddr_r <= '0;
        end
        else if (wr_go)
        begin
            if (wb_adr_i == OFF_DADDR)
            begin
                daddr_r <= DATA_AW'(merge(32'(daddr_r), wb_dat_i, wmask));
            end
            if (!reg_busy && wb_adr_i == OFF_CTRL && wb_sel_i[0])
            begin
                ext_en_r <= wb_dat_i[0];
            end
            if (!reg_busy && wb_adr_i == OFF_BANK && wb_sel_i[0])
            begin
                bank_r <= wb_dat_i[3:0];
            end
            if (!reg_busy && wb_adr_i == OFF_IBASE)
            begin
                ibase_r <= FADDR_W'(merge(32'(ibase_r), wb_dat_i, wmask));
            end
        end
    end

    // flags come only from software; nothing executed here alters them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_r <= FLAGS_RST;
        end
        else if (wr_go && !reg_busy && wb_adr_i == OFF_FLAGS && wb_sel_i[0])
        begin
            flags_r <= wb_dat_i[7:0];
        end
    end

    // one instruction word per issue write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pending_r <= 1'b0;
            instr_r <= INSTR_RST;
        end
        else if (wr_go && !reg_busy && wb_adr_i == OFF_INSTR)
        begin
            pending_r <= 1'b1;
            instr_r <= INSTR_W'(merge(32'(instr_r), wb_dat_i, wmask));
        end
        else if (idle && cycle_end)
        begin
            pending_r <= 1'b0;
        end
    end

    // execution sequencer, aligned to instruction cycle boundaries
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= SM_IDLE;
        end
        else
        begin
            case (state_r)
                SM_IDLE:
                begin
                    if (pending_r && cycle_end)
                    begin
                        state_r <= SM_EXEC;
                    end
                end
                SM_EXEC:
                begin
                    if (cycle_end)
                    begin
                        state_r <= taken_r ? SM_NOP : SM_IDLE;
                    end
                end
                SM_NOP:
                begin
                    if (cycle_end)
                    begin
                        state_r <= SM_IDLE;
                    end
                end
                default:
                begin
                    state_r <= SM_IDLE;
                end
            endcase
        end
    end

    // first phase latches the decode so flags are sampled once per instruction
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            kind_r <= KIND_NONE;
            taken_r <= 1'b0;
            off2_r <= '0;
            faddr_r <= '0;
            bit_r <= 3'h0;
        end
        else if (state_r == SM_EXEC && phase == Q_DECODE)
        begin
            kind_r <= dec_kind;
            taken_r <= dec_taken;
            off2_r <= dec_off2;
            faddr_r <= dec_faddr;
            bit_r <= dec_bit;
        end
    end

    // program counter: bumped past the word at decode, retargeted at the write phase
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_r <= PC_RST;
        end
        else if (state_r == SM_EXEC && phase == Q_DECODE)
        begin
            pc_r <= pc_r + PC_W'(2);
        end
        else if (state_r == SM_EXEC && phase == Q_WRITE && taken_r)
        begin
            pc_r <= pc_r + off2_r;
        end
        else if (wr_go && !reg_busy && wb_adr_i == OFF_PC)
        begin
            pc_r <= PC_W'(merge(32'(pc_r), wb_dat_i, wmask));
        end
    end

    // bit set read-modify-write: read, merge, write back
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_r <= 8'h00;
            wr_r <= 8'h00;
        end
        else if (state_r == SM_EXEC && phase == Q_READ)
        begin
            rd_r <= mem_r[faddr_r[DATA_AW-1:0]];
        end
        else if (state_r == SM_EXEC && phase == Q_PROCESS)
        begin
            wr_r <= rd_r | (8'h01 << bit_r);
        end
    end

    // data memory holds no reset; it is ordinary file storage
    always_ff @(posedge clk_i)
    begin
        if (state_r == SM_EXEC && phase == Q_WRITE && kind_r == KIND_FBSET)
        begin
            mem_r[faddr_r[DATA_AW-1:0]] <= wr_r;
        end
        else if (wr_go && !reg_busy && wb_adr_i == OFF_DDATA && wb_sel_i[0])
        begin
            mem_r[daddr_r] <= wb_dat_i[7:0];
        end
    end

    // status of the last finished instruction
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            last_taken_r <= 1'b0;
            unsup_r <= 1'b0;
        end
        else if (state_r == SM_EXEC && phase == Q_WRITE)
        begin
            last_taken_r <= taken_r;
            unsup_r <= (kind_r == KIND_NONE);
        end
    end

    // refused writes are sticky; a refusal in the clearing cycle survives
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            refused_r <= 1'b0;
        end
        else if (refuse_ev)
        begin
            refused_r <= 1'b1;
        end
        else if (wr_go && wb_adr_i == OFF_STATE && wb_sel_i[0] && wb_dat_i[ST_REFUSED])
        begin
            refused_r <= 1'b0;
        end
    end

    // registered copy of busy for busy_o; the other outputs drive straight from their registers
    logic busy_r;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_r <= 1'b0;
        end
        else
        begin
            busy_r <= (state_r != SM_IDLE) | pending_r;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign pc_o = pc_r;
    assign busy_o = busy_r;

endmodule : rbx_exec_core

// file: logic/rbx_pkg.sv
/*
 * rbx_pkg: shared constants and types for the relative branch and file bit set
 * execution block.
 * assumes: one 100 MHz clock, one core instruction cycle of four clock phases.
 */
package rbx_pkg;

    // word sizes
    localparam int PC_W = 21;
    localparam int INSTR_W = 16;
    localparam int FADDR_W = 12;
    localparam int DATA_AW_DFLT = 12;
    localparam int WB_AW = 8;

    // instruction cycle made of four phases, one clock each
    localparam int Q_PHASES = 4;
    localparam logic [1:0] Q_DECODE = 2'h0;
    localparam logic [1:0] Q_READ = 2'h1;
    localparam logic [1:0] Q_PROCESS = 2'h2;
    localparam logic [1:0] Q_WRITE = 2'h3;

    // opcode prefixes
    localparam logic [7:0] OPC_CARRY_CLR = 8'he3;
    localparam logic [7:0] OPC_SIGN_CLR = 8'he7;
    localparam logic [7:0] OPC_OVF_CLR = 8'he5;
    localparam logic [7:0] OPC_NONZERO = 8'he1;
    localparam logic [4:0] OPC_JUMP = 5'h1a;
    localparam logic [3:0] OPC_FBSET = 4'h8;

    // data addressing
    localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
    localparam logic [3:0] ACCESS_UPPER_BANK = 4'hf;

    // status flag bit positions
    localparam int FLG_CARRY = 0;
    localparam int FLG_ZERO = 2;
    localparam int FLG_OVF = 3;
    localparam int FLG_SIGN = 4;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_PC = 8'h08;
    localparam logic [7:0] OFF_BANK = 8'h0c;
    localparam logic [7:0] OFF_IBASE = 8'h10;
    localparam logic [7:0] OFF_INSTR = 8'h14;
    localparam logic [7:0] OFF_STATE = 8'h18;
    localparam logic [7:0] OFF_DADDR = 8'h1c;
    localparam logic [7:0] OFF_DDATA = 8'h20;

    // state register bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_TAKEN = 1;
    localparam int ST_UNSUP = 2;
    localparam int ST_REFUSED = 3;

    // values after reset
    localparam logic [PC_W-1:0] PC_RST = 21'h000000;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [FADDR_W-1:0] IBASE_RST = 12'h000;
    localparam logic [INSTR_W-1:0] INSTR_RST = 16'h0000;

    typedef enum logic [1:0] {
        KIND_NONE = 2'h0,
        KIND_COND = 2'h1,
        KIND_JUMP = 2'h2,
        KIND_FBSET = 2'h3
    } rbx_kind_t;

    typedef enum logic [2:0] {
        SM_IDLE = 3'b001,
        SM_EXEC = 3'b010,
        SM_NOP = 3'b100
    } rbx_state_t;

endpackage : rbx_pkg

// file: logic/rbx_qphase.sv
/*
 * rbx_qphase: four-phase instruction cycle sequencer.
 * assumes: synchronous active-high reset; phase 0 follows the reset release.
 */
`timescale 1ns/1ps

module rbx_qphase
    import rbx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    output logic [1:0] phase_o,
    output logic cycle_end_o
);

    logic [1:0] phase_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_r <= Q_DECODE;
        end
        else
        begin
            phase_r <= phase_r + 2'h1;
        end
    end

    assign phase_o = phase_r;
    assign cycle_end_o = (phase_r == Q_WRITE);

endmodule : rbx_qphase

// file: logic/rbx_decode.sv
/*
 * rbx_decode: combinational decode of one instruction word into kind,
 * branch decision, doubled offset and file address.
 * assumes: flags and bank state are stable while the word is decoded.
 */
`timescale 1ns/1ps

module rbx_decode
    import rbx_pkg::*;
(
    input wire logic [INSTR_W-1:0] instr_i,
    input wire logic [7:0] flags_i,
    input wire logic [3:0] bank_i,
    input wire logic ext_en_i,
    input wire logic [FADDR_W-1:0] ibase_i,
    output rbx_kind_t kind_o,
    output logic taken_o,
    output logic [PC_W-1:0] offset2_o,
    output logic [FADDR_W-1:0] faddr_o,
    output logic [2:0] bit_o
);

    logic [7:0] f;

    assign f = instr_i[7:0];
    assign bit_o = instr_i[11:9];

    always_comb
    begin
        kind_o = KIND_NONE;
        taken_o = 1'b0;
        offset2_o = {{(PC_W-9){instr_i[7]}}, instr_i[7:0], 1'b0};
        case (instr_i[15:8])
            OPC_CARRY_CLR:
            begin
                kind_o = KIND_COND;
                taken_o = ~flags_i[FLG_CARRY];
            end
            OPC_SIGN_CLR:
            begin
                kind_o = KIND_COND;
                taken_o = ~flags_i[FLG_SIGN];
            end
            OPC_OVF_CLR:
            begin
                kind_o = KIND_COND;
                taken_o = ~flags_i[FLG_OVF];
            end
            OPC_NONZERO:
            begin
                kind_o = KIND_COND;
                taken_o = ~flags_i[FLG_ZERO];
            end
            default:
            begin
                if (instr_i[15:11] == OPC_JUMP)
                begin
                    kind_o = KIND_JUMP;
                    taken_o = 1'b1;
                    offset2_o = {{(PC_W-12){instr_i[10]}}, instr_i[10:0], 1'b0};
                end
                else if (instr_i[15:12] == OPC_FBSET)
                begin
                    kind_o = KIND_FBSET;
                end
            end
        endcase
    end

    always_comb
    begin
        if (instr_i[8])
        begin
            faddr_o = {bank_i, f};
        end
        else if (f <= ACCESS_LIMIT && ext_en_i)
        begin
            faddr_o = ibase_i + {4'h0, f};
        end
        else if (f <= ACCESS_LIMIT)
        begin
            faddr_o = {4'h0, f};
        end
        else
        begin
            faddr_o = {ACCESS_UPPER_BANK, f};
        end
    end

endmodule : rbx_decode

// file: test/rbx_exec_sva.sv
/*
 * rbx_exec_sva: port-level checker for rbx_exec_core, bound into it.
 * assumes: a classic single-cycle Wishbone master that holds its request until ack.
 */
`timescale 1ns/1ps

module rbx_exec_sva
    import rbx_pkg::*;
#(
    parameter int DATA_AW = DATA_AW_DFLT
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [PC_W-1:0] pc_o,
    input wire logic busy_o
);
    logic instr_wr;

    assign instr_wr = wb_ack_o && wb_we_i && wb_adr_i == OFF_INSTR;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in the next cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    unmapped_reads_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h23 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    pc_load_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == OFF_PC && wb_sel_i == 4'hf && !busy_o
        |=> pc_o == $past(wb_dat_i[PC_W-1:0]))
        else $error("program counter write lost");
    pc_change_cause_a: assert property ($changed(pc_o) |-> busy_o || $past(busy_o) || $past(wb_ack_o && wb_we_i))
        else $error("program counter moved while idle");
    busy_min_a: assert property ($rose(busy_o) |-> busy_o [*4])
        else $error("instruction shorter than one instruction cycle");
    busy_max_a: assert property ($rose(busy_o) |-> ##[4:14] !busy_o)
        else $error("instruction longer than two instruction cycles");
    busy_cause_a: assert property ($rose(busy_o) |-> $past(instr_wr) || $past(instr_wr, 2) || $past(instr_wr, 3))
        else $error("busy without an issued instruction");
endmodule : rbx_exec_sva

bind rbx_exec_core rbx_exec_sva #(.DATA_AW(DATA_AW)) i_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc_o(pc_o), .busy_o(busy_o));

// file: test/rbx_tb.sv
/*
 * tb: self-checking bench for rbx_exec_core over its Wishbone port.
 * assumes: the block's register map and single-cycle bus answer; data memory unused until written.
 */
`timescale 1ns/1ps

module tb
    import rbx_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, chk = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, junk, wb_dat_o;
    logic wb_ack_o, busy_o;
    logic [PC_W-1:0] pc_o;
    int failures = 0;
    int n_checks = 0;
    int bcnt = 0;
    logic [31:0] exp_q[$];
    logic [31:0] ev;
    logic len_q[$];
    logic [7:0] ops [4] = '{OPC_CARRY_CLR, OPC_SIGN_CLR, OPC_OVF_CLR, OPC_NONZERO};
    int idx [4] = '{FLG_CARRY, FLG_SIGN, FLG_OVF, FLG_ZERO};

    always #5 clk_i = ~clk_i;

    rbx_exec_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pc_o(pc_o), .busy_o(busy_o));

    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch at %0t: read %h expected %h", $time, g, e);
        end
    endtask : cmp_word

    task automatic cmp_len(input logic t, input int c);
        int lo;
        lo = (t === 1'b1) ? 8 : 4;
        n_checks++;
        if (c < lo || c > lo + 4)
        begin
            failures++;
            $display("mismatch at %0t: busy for %0d clocks", $time, c);
        end
    endtask : cmp_len

    // results are judged here, in order of issue, as they appear at the ports
    always @(posedge clk_i)
    begin
        if (!rst_i && wb_ack_o === 1'b1 && chk && !we)
        begin
            ev = exp_q.pop_front();
            cmp_word(ev, wb_dat_o);
            // the counter port must agree with the register view of it
            if (adr == OFF_PC)
                cmp_word(ev, {11'h0, pc_o});
        end
        if (busy_o === 1'b1)
            bcnt++;
        else if (bcnt > 0)
        begin
            cmp_len(len_q.pop_front(), bcnt);
            bcnt = 0;
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
        input logic [31:0] e, output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        chk <= c;
        if (c)
            exp_q.push_back(e);
        @(posedge clk_i);
        n = 1;
        while (wb_ack_o !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        if (wb_ack_o !== 1'b1)
        begin
            failures++;
            $display("mismatch at %0t: no ack", $time);
            give_verdict();
        end
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0, 32'h0, junk);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 1'b1, e, junk);
    endtask : rdc

    // issue one instruction and poll until it has retired
    task automatic run(input logic [15:0] ins, input logic t, input logic poke = 1'b0);
        logic [31:0] rd;
        int k;
        len_q.push_back(t);
        wr(OFF_INSTR, {16'h0, ins});
        // a counter write while the word is in flight must bounce and be noted
        if (poke)
            wr(OFF_PC, 32'h0000_0000);
        for (k = 0; k < 20; k++)
        begin
            bus(1'b0, OFF_STATE, 32'h0, 1'b0, 32'h0, rd);
            if (rd[ST_BUSY] === 1'b0)
                break;
        end
        if (k == 20)
        begin
            failures++;
            $display("mismatch at %0t: instruction never retired", $time);
            give_verdict();
        end
    endtask : run

    initial
    begin
        logic [PC_W-1:0] p, e;
        logic [7:0] f8, n8, v;
        logic [10:0] n11;
        logic [11:0] ad, ib;
        logic [3:0] bk;
        logic [2:0] b;
        logic t, a;
        junk = $urandom(32'h06ac);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(OFF_PC, 32'h0);
        rdc(8'h40, 32'h0);
        for (int i = 0; i < 4; i++)
            for (int j = 0; j < 4; j++)
            begin
                n8 = (j == 0) ? 8'h80 : (j == 1) ? 8'h7f : 8'($urandom);
                f8 = 8'($urandom) & 8'h1d;
                f8[idx[i]] = j[0];
                t = ~j[0];
                p = 21'($urandom) & ~21'h1;
                wr(OFF_FLAGS, {24'h0, f8});
                wr(OFF_PC, {11'h0, p});
                run({ops[i], n8}, t);
                e = p + 21'd2 + (t ? {{12{n8[7]}}, n8, 1'b0} : 21'h0);
                rdc(OFF_PC, {11'h0, e});
                rdc(OFF_STATE, {30'h0, t, 1'b0});
                rdc(OFF_FLAGS, {24'h0, f8});
            end
        for (int j = 0; j < 3; j++)
        begin
            n11 = (j == 0) ? 11'h400 : (j == 1) ? 11'h3ff : 11'($urandom);
            p = 21'($urandom) & ~21'h1;
            wr(OFF_FLAGS, 32'h1d);
            wr(OFF_PC, {11'h0, p});
            run({OPC_JUMP, n11}, 1'b1);
            rdc(OFF_PC, {11'h0, p + 21'd2 + {{9{n11[10]}}, n11, 1'b0}});
        end
        for (int j = 0; j < 4; j++)
        begin
            // bank register first, then access bank above the low window, then below it without and with indexing
            a = (j == 0);
            f8 = (j == 1) ? 8'h60 + 8'($urandom % 160) : (j > 1) ? 8'($urandom % 96) : 8'($urandom);
            bk = 4'($urandom);
            ib = 12'($urandom);
            v = 8'($urandom);
            b = 3'($urandom);
            wr(OFF_BANK, {28'h0, bk});
            wr(OFF_IBASE, {20'h0, ib});
            wr(OFF_CTRL, {31'h0, j == 3});
            ad = a ? {bk, f8} : (f8 > ACCESS_LIMIT) ? {ACCESS_UPPER_BANK, f8} : (j == 3) ? ib + {4'h0, f8} : {4'h0, f8};
            wr(OFF_DADDR, {20'h0, ad});
            wr(OFF_DDATA, {24'h0, v});
            run({OPC_FBSET, b, a, f8}, 1'b0);
            wr(OFF_DADDR, {20'h0, ad});
            rdc(OFF_DDATA, {24'h0, v | (8'h1 << b)});
        end
        wr(OFF_CTRL, 32'h0);
        wr(OFF_PC, 32'h100);
        run(16'h0000, 1'b0, 1'b1);
        rdc(OFF_PC, 32'h102);
        rdc(OFF_STATE, 32'h0000_000c);
        wr(OFF_STATE, 32'h0000_0008);
        rdc(OFF_STATE, 32'h0000_0004);
        give_verdict();
    end

    initial
    begin
        repeat (100000) @(posedge clk_i);
        failures++;
        $display("mismatch at %0t: run limit reached", $time);
        give_verdict();
    end
endmodule : tb
